/* logic/sysctl_regs.svh */
// Constants for the processor system control sequencer.
// Assumes inclusion by bare name from logic/ and test/ files.
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH
`define RESET_VECTOR 32'hFFFFFFF0
`define MGMT_BASE 32'h00038000
`define MGMT_LEAD_EDGES 3
`define CLK_PERIOD_NS 10
`define POR_HOLD_NS 1000000
`define POR_HOLD_CYCLES ((`POR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARM_HOLD_CYCLES 15
`endif

/* logic/sysctl_pkg.sv */
// Types shared by the system control sequencer files.
// Assumes no other package.
package sysctl_pkg;
	typedef enum logic [6:0] {
		ST_RUN = 7'h01,
		ST_MGMT_DRAIN = 7'h02,
		ST_MGMT = 7'h04,
		ST_MGMT_EXIT = 7'h08,
		ST_HALT_DRAIN = 7'h10,
		ST_GRANT_CYCLE = 7'h20,
		ST_GRANT = 7'h40
	} seq_state_t;
endpackage : sysctl_pkg

/* logic/sync_if.sv */
// Interface carrying synchronised pin levels to the sequencer core.
// Assumes a single clock.
`timescale 1ns/1ps
interface sync_if;
	logic mgmt_n;
	logic halt_n;
	logic reset_lvl;
	modport src (output mgmt_n, output halt_n, output reset_lvl);
	modport dst (input mgmt_n, input halt_n, input reset_lvl);
endinterface : sync_if

/* logic/pin_sync.sv */
// Two-stage synchronisers for the asynchronous control pins.
// Assumes pins idle high (inactive) except reset.
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Pins
	input wire logic mgmt_interrupt_n,
	input wire logic clock_halt_request_n,
	input wire logic cpu_reset,
	// Synchronised levels
	sync_if.src sync
);
	logic [2:0] stage1_reg;
	logic [2:0] stage2_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= 3'h3;
			stage2_reg <= 3'h3;
		end else begin
			stage1_reg <= {cpu_reset, clock_halt_request_n, mgmt_interrupt_n};
			stage2_reg <= stage1_reg;
		end
	end
	assign sync.mgmt_n = stage2_reg[0];
	assign sync.halt_n = stage2_reg[1];
	assign sync.reset_lvl = stage2_reg[2];
endmodule : pin_sync

/* logic/mgmt_edge_latch.sv */
// Falling-edge latch for the management interrupt request.
// Assumes a synchronised, active-low input level.
`timescale 1ns/1ps
module mgmt_edge_latch (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	input wire logic flush,
	// Request
	input wire logic level_n,
	input wire logic take,
	output logic pending
);
	logic prev_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_reg <= 1'h1;
		end else begin
			prev_reg <= level_n;
		end
	end
	// Edge wins over a same-cycle take
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pending <= 1'h0;
		end else if (flush) begin
			pending <= 1'h0;
		end else if (prev_reg && !level_n) begin
			pending <= 1'h1; // R07 R10
		end else if (take) begin
			pending <= 1'h0;
		end
	end
endmodule : mgmt_edge_latch

/* logic/cpu_system_control_sequencer.sv */
// Processor-side sequencer for reset, management mode and clock halt.
// Assumes the core reports instruction boundaries, bus idleness and
// the management-exit event; burst_ready_n and write_buffer_empty_n are
// synchronous to clock.
`timescale 1ns/1ps
`include "sysctl_regs.svh"

// Function
// R01: Reset sampled active flushes all state, then fetch starts at reset vector.
// R02: Reset release captures drive-strength select and tri-state test request.
// R03: Reset is a level sampled every clock, sync or async.
// R04: Power-on reset held at least 1 ms by system logic.
// R05: Warm reset held at least 15 clocks by system logic.
// R06: Management entry: flush, drain bus, acknowledge, save, mask, jump to base.
// R07: Management interrupt falling edge latched, acted on at instruction boundary.
// R08: Management request must lead burst-ready by three edges for that boundary.
// R09: Management interrupt pulse widths: one clock sync, two inactive/two active async.
// R10: Edge during management mode stays pending until the routine exits.
// R11: Acknowledge only after final burst-ready and write-buffer-empty unless masked.
// R12: Acknowledge held until final burst-ready of the exit's last cycle.
// R13: Acknowledge not dropped by flush, snoop or writeback in management mode.
// R14: Halt request: flush, drain, stop-grant cycle, gate clock after ready and empty.
// R15: Bus clock stop from stop-grant is the stop-clock state.
// R16: Halt request sampled as level, acted on at instruction boundary.
// R17: System logic holds halt request until the stop-grant cycle completes.
// R18: Halt request negated in stop-grant restarts clock and resumes.
// R19: A setting masks write-buffer-empty for acknowledge and stop-grant entry.
module cpu_system_control_sequencer
	import sysctl_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// System pins
	input wire logic cpu_reset,
	input wire logic mgmt_interrupt_n,
	input wire logic clock_halt_request_n,
	input wire logic burst_ready_n,
	input wire logic write_buffer_empty_n,
	input wire logic drive_strength_select,
	input wire logic cache_flush_n,
	output logic mgmt_active_n,
	// Configuration
	input wire logic wbe_mask,
	// Core handshake
	input wire logic instr_boundary,
	input wire logic bus_idle,
	input wire logic mgmt_exit,
	output logic core_flush,
	output logic pipe_flush,
	output logic [31:0] fetch_addr,
	output logic fetch_load,
	output logic save_state,
	output logic nmi_block,
	output logic int_flag_clear,
	output logic grant_cycle_req,
	output logic internal_clk_en,
	output logic stop_grant,
	// Strap captures
	output logic strong_drive,
	output logic tristate_test
);
	import sysctl_pkg::*;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	sync_if sync();
	pin_sync u_sync (
		.clock(clock),
		.resetn(resetn),
		.mgmt_interrupt_n(mgmt_interrupt_n),
		.clock_halt_request_n(clock_halt_request_n),
		.cpu_reset(cpu_reset),
		.sync(sync.src)
	);

	seq_state_t state_reg;
	seq_state_t state_next;
	logic reset_prev_reg;
	logic mgmt_pending;
	logic mgmt_take;
	logic wbe_ok;
	logic last_ready;
	logic reset_fall;
	logic mode_entry;
	logic [1:0] strap_dly_reg;

	assign reset_fall = reset_prev_reg && !sync.reset_lvl;
	assign wbe_ok = wbe_mask || !write_buffer_empty_n; // R19
	assign last_ready = !burst_ready_n && bus_idle;

	mgmt_edge_latch u_latch (
		.clock(clock),
		.resetn(resetn),
		.flush(sync.reset_lvl),
		.level_n(sync.mgmt_n),
		.take(mgmt_take),
		.pending(mgmt_pending)
	);

	// ----------------------------------------
	// Reset level and strap capture
	// ----------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Idle level of the reset pin, so a block reset shows no false release
			reset_prev_reg <= 1'h0;
		end else begin
			reset_prev_reg <= sync.reset_lvl; // R03
		end
	end

	// Flush strap comes from an asynchronous pin: two flip-flops, idle high
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strap_dly_reg <= 2'h3;
		end else begin
			strap_dly_reg <= {strap_dly_reg[0], cache_flush_n};
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strong_drive <= 1'h0;
			tristate_test <= 1'h0;
		end else if (reset_fall) begin
			strong_drive <= drive_strength_select; // R02
			tristate_test <= !strap_dly_reg[1]; // R02
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign mgmt_take = (state_reg == ST_RUN) && instr_boundary && mgmt_pending; // R07 R10
	assign mode_entry = !sync.reset_lvl && state_reg == ST_MGMT_DRAIN && state_next == ST_MGMT; // R06 R11

	// True in the two states in which the acknowledge stands
	function automatic logic in_mode(input seq_state_t st);
		return (st == ST_MGMT) || (st == ST_MGMT_EXIT);
	endfunction : in_mode

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (mgmt_take) begin
					state_next = ST_MGMT_DRAIN; // R06
				end else if (instr_boundary && !sync.halt_n) begin
					state_next = ST_HALT_DRAIN; // R14 R16
				end
			end
			ST_MGMT_DRAIN: begin
				if (bus_idle && wbe_ok) begin
					state_next = ST_MGMT; // R11
				end
			end
			ST_MGMT: begin
				if (mgmt_exit) begin
					state_next = ST_MGMT_EXIT;
				end
			end
			ST_MGMT_EXIT: begin
				if (last_ready) begin
					state_next = ST_RUN; // R12
				end
			end
			ST_HALT_DRAIN: begin
				if (bus_idle) begin
					state_next = ST_GRANT_CYCLE;
				end
			end
			ST_GRANT_CYCLE: begin
				if (!burst_ready_n && wbe_ok) begin
					state_next = ST_GRANT; // R14
				end
			end
			ST_GRANT: begin
				if (sync.halt_n) begin
					state_next = ST_RUN; // R18
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_RUN;
		end else if (sync.reset_lvl) begin
			state_reg <= ST_RUN; // R01
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Acknowledge follows state and reset only; flush or snoop traffic cannot drop it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mgmt_active_n <= 1'h1;
		end else if (sync.reset_lvl) begin
			mgmt_active_n <= 1'h1;
		end else begin
			mgmt_active_n <= !in_mode(state_next); // R11 R12 R13
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fetch_addr <= `RESET_VECTOR;
			fetch_load <= 1'h0;
		end else if (reset_fall) begin
			fetch_addr <= `RESET_VECTOR; // R01
			fetch_load <= 1'h1;
		end else if (mode_entry) begin
			fetch_addr <= `MGMT_BASE; // R06
			fetch_load <= 1'h1;
		end else begin
			fetch_load <= 1'h0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			save_state <= 1'h0;
			int_flag_clear <= 1'h0;
		end else begin
			save_state <= mode_entry; // R06
			int_flag_clear <= mode_entry; // R06
		end
	end

	assign nmi_block = in_mode(state_reg); // R06
	assign core_flush = sync.reset_lvl; // R01
	assign pipe_flush = mgmt_take || (state_reg == ST_RUN && state_next == ST_HALT_DRAIN); // R06 R14
	assign grant_cycle_req = (state_reg == ST_GRANT_CYCLE);
	assign stop_grant = (state_reg == ST_GRANT); // R15
	assign internal_clk_en = (state_reg != ST_GRANT); // R14 R18

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_drain_done;
		state_reg == ST_MGMT_DRAIN && bus_idle && wbe_ok && !sync.reset_lvl;
	endsequence

	sequence s_grant_done;
		state_reg == ST_GRANT_CYCLE && !burst_ready_n && wbe_ok && !sync.reset_lvl;
	endsequence

	chk_ack_after_drain: assert property (@(posedge clock) disable iff (!resetn) // R11
		s_drain_done |=> !mgmt_active_n) else $error("acknowledge late after drain");
	chk_ack_needs_drain: assert property (@(posedge clock) disable iff (!resetn) // R11
		$fell(mgmt_active_n) |-> $past(bus_idle) && ($past(wbe_mask) || !$past(write_buffer_empty_n)))
		else $error("acknowledge before drain");
	chk_ack_held_exit: assert property (@(posedge clock) disable iff (!resetn) // R12
		$rose(mgmt_active_n) && !$past(sync.reset_lvl) |-> $past(last_ready))
		else $error("acknowledge dropped early");
	chk_ack_steady_mgmt: assert property (@(posedge clock) disable iff (!resetn) // R13
		state_reg == ST_MGMT && !sync.reset_lvl |=> !mgmt_active_n) else $error("acknowledge dropped in mode");
	chk_reset_vector: assert property (@(posedge clock) disable iff (!resetn) // R01
		reset_fall |=> fetch_load && fetch_addr == `RESET_VECTOR) else $error("bad reset vector");
	chk_mgmt_base: assert property (@(posedge clock) disable iff (!resetn) // R06
		$fell(mgmt_active_n) |-> fetch_load && fetch_addr == `MGMT_BASE) else $error("bad management base");
	chk_strap_capture: assert property (@(posedge clock) disable iff (!resetn) // R02
		reset_fall |=> strong_drive == $past(drive_strength_select)) else $error("strap not captured");
	chk_grant_clock: assert property (@(posedge clock) disable iff (!resetn) // R14
		s_grant_done |=> !internal_clk_en)
		else $error("clock not gated");
	chk_grant_resume: assert property (@(posedge clock) disable iff (!resetn) // R18
		stop_grant && sync.halt_n && !sync.reset_lvl |=> internal_clk_en) else $error("no resume");
	chk_edge_pending: assert property (@(posedge clock) disable iff (!resetn) // R10
		nmi_block && $fell(sync.mgmt_n) |=> mgmt_pending) else $error("edge lost in mode");
	chk_halt_boundary: assert property (@(posedge clock) disable iff (!resetn) // R16
		$rose(state_reg == ST_HALT_DRAIN) |-> $past(instr_boundary)) else $error("halt off boundary");

	// ----------------------------------------
	// Checks on reset, entry and halt
	// ----------------------------------------
	chk_reset_forces_run: assert property (@(posedge clock) disable iff (!resetn) // R01
		sync.reset_lvl |=> state_reg == ST_RUN && mgmt_active_n)
		else $error("reset did not return to run");
	chk_flush_strap: assert property (@(posedge clock) disable iff (!resetn) // R02
		reset_fall |=> tristate_test == !$past(cache_flush_n, 3))
		else $error("flush strap not captured");
	chk_mode_blocks_nmi: assert property (@(posedge clock) disable iff (!resetn) // R06
		!mgmt_active_n |-> nmi_block)
		else $error("nmi not blocked in mode");
	chk_save_with_ack: assert property (@(posedge clock) disable iff (!resetn) // R06
		$fell(mgmt_active_n) |-> save_state && int_flag_clear)
		else $error("state save missing at entry");
	chk_fetch_one_cycle: assert property (@(posedge clock) disable iff (!resetn) // R01 R06
		fetch_load |=> !fetch_load)
		else $error("fetch start longer than one cycle");
	chk_take_boundary: assert property (@(posedge clock) disable iff (!resetn) // R07
		$rose(state_reg == ST_MGMT_DRAIN) |-> $past(instr_boundary) && $past(mgmt_pending))
		else $error("management taken off boundary");
	chk_pending_kept: assert property (@(posedge clock) disable iff (!resetn) // R10
		mgmt_pending && !mgmt_take && !sync.reset_lvl |=> mgmt_pending)
		else $error("pending request lost");
	chk_halt_flush: assert property (@(posedge clock) disable iff (!resetn) // R14
		$rose(state_reg == ST_HALT_DRAIN) |-> $past(pipe_flush))
		else $error("no flush before halt drain");
	chk_grant_after_drain: assert property (@(posedge clock) disable iff (!resetn) // R14
		$rose(grant_cycle_req) |-> $past(bus_idle) && $past(state_reg) == ST_HALT_DRAIN)
		else $error("stop-grant cycle before drain");
	chk_grant_needs_ready: assert property (@(posedge clock) disable iff (!resetn) // R14 R19
		$rose(stop_grant) |-> !$past(burst_ready_n) && ($past(wbe_mask) || !$past(write_buffer_empty_n)))
		else $error("stop grant before ready");
endmodule : cpu_system_control_sequencer

/* test/chipset_model.sv */
// Behavioural model of the chipset on the processor bus: burst ready and write buffer.
// Assumes the bench asks for ordinary cycles with kick, one at a time.
`timescale 1ns/1ps
module chipset_model (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Requests
	input wire logic grant_cycle_req,
	input wire logic kick,
	input wire logic [3:0] ready_delay,
	input wire logic [3:0] drain_delay,
	// Answers
	output logic burst_ready_n,
	output logic write_buffer_empty_n
);
	logic busy_reg;
	logic [3:0] wait_reg;
	logic [3:0] drain_reg;
	// Answers a cycle, or the stop-grant cycle, after a chosen delay
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			wait_reg <= 4'h0;
			burst_ready_n <= 1'b1;
		end else begin
			burst_ready_n <= 1'b1;
			if (busy_reg) begin
				if (wait_reg == 4'h0) begin
					burst_ready_n <= 1'b0;
					busy_reg <= 1'b0;
				end else begin
					wait_reg <= wait_reg - 4'h1;
				end
			end else if ((grant_cycle_req && burst_ready_n) || kick) begin
				busy_reg <= 1'b1;
				wait_reg <= ready_delay;
			end
		end
	end
	// Posted data drains for a while after each cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			drain_reg <= 4'h0;
		end else if (!burst_ready_n) begin
			drain_reg <= drain_delay;
		end else if (drain_reg != 4'h0) begin
			drain_reg <= drain_reg - 4'h1;
		end
	end
	assign write_buffer_empty_n = (drain_reg != 4'h0);
endmodule : chipset_model

/* test/cpu_system_control_sequencer_tb.sv */
// Self-checking bench for the system control sequencer.
// Assumes chipset_model and the design files; inputs change at the falling edge.
`timescale 1ns/1ps
`include "sysctl_regs.svh"
module cpu_system_control_sequencer_tb;
	import sysctl_pkg::*;
	logic clock = 1'b0, resetn = 1'b0, cpu_reset = 1'b0, mgmt_interrupt_n = 1'b1, clock_halt_request_n = 1'b1;
	logic drive_strength_select = 1'b0, cache_flush_n = 1'b1, wbe_mask = 1'b0, instr_boundary = 1'b0;
	logic bus_idle = 1'b1, mgmt_exit = 1'b0, kick = 1'b0, dss, cfn;
	logic [3:0] ready_delay = 4'h1, drain_delay = 4'h6;
	logic burst_ready_n, write_buffer_empty_n, mgmt_active_n, core_flush, pipe_flush, fetch_load, save_state;
	logic nmi_block, int_flag_clear, grant_cycle_req, internal_clk_en, stop_grant, strong_drive, tristate_test;
	logic [31:0] fetch_addr;
	logic [31:0] exp_q[$];
	logic want_save;
	int bad_count = 0, n_compared = 0, cycles = 0, n_flush = 0, i, m;
	cpu_system_control_sequencer dut (.clock(clock), .resetn(resetn), .cpu_reset(cpu_reset),
		.mgmt_interrupt_n(mgmt_interrupt_n), .clock_halt_request_n(clock_halt_request_n),
		.burst_ready_n(burst_ready_n), .write_buffer_empty_n(write_buffer_empty_n),
		.drive_strength_select(drive_strength_select), .cache_flush_n(cache_flush_n),
		.mgmt_active_n(mgmt_active_n), .wbe_mask(wbe_mask), .instr_boundary(instr_boundary),
		.bus_idle(bus_idle), .mgmt_exit(mgmt_exit), .core_flush(core_flush), .pipe_flush(pipe_flush),
		.fetch_addr(fetch_addr), .fetch_load(fetch_load), .save_state(save_state), .nmi_block(nmi_block),
		.int_flag_clear(int_flag_clear), .grant_cycle_req(grant_cycle_req), .internal_clk_en(internal_clk_en),
		.stop_grant(stop_grant), .strong_drive(strong_drive), .tristate_test(tristate_test));
	chipset_model partner (.clock(clock), .resetn(resetn), .grant_cycle_req(grant_cycle_req), .kick(kick),
		.ready_delay(ready_delay), .drain_delay(drain_delay), .burst_ready_n(burst_ready_n),
		.write_buffer_empty_n(write_buffer_empty_n));
	initial begin
		forever #5 clock = ~clock;
	end
	// --------------------------------------------------------------
	// Checking helpers
	// --------------------------------------------------------------
	task automatic wrap_up;
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic got, input logic want);
		n_compared++;
		if (got !== want) begin
			bad_count++;
			$display("Error at %0t: output level mismatch", $time);
		end
	endtask : chk
	function automatic logic pick(input int which);
		case (which)
			0: return mgmt_active_n;
			1: return grant_cycle_req;
			default: return stop_grant;
		endcase
	endfunction : pick
	task automatic wait_sig(input int which, input logic val);
		int k;
		for (k = 0; k < 60; k++) begin
			@(negedge clock);
			if (pick(which) === val) break;
		end
		chk(pick(which), val);
	endtask : wait_sig
	task automatic pulse(input int which);
		if (which == 0) instr_boundary = 1'b1;
		else if (which == 1) mgmt_exit = 1'b1;
		else if (which == 2) kick = 1'b1;
		else mgmt_interrupt_n = 1'b0;
		@(negedge clock);
		if (which == 0) instr_boundary = 1'b0;
		else if (which == 1) mgmt_exit = 1'b0;
		else if (which == 2) kick = 1'b0;
		else mgmt_interrupt_n = 1'b1;
	endtask : pulse
	// Each fetch start is compared with the bench's queue of expected vectors
	always @(negedge clock) begin
		want_save = fetch_load === 1'b1 && exp_q.size() != 0 && exp_q[0] == `MGMT_BASE;
		if (save_state !== want_save || int_flag_clear !== want_save) begin
			bad_count++;
			$display("Error at %0t: state save pulse mismatch", $time);
		end
		if (fetch_load === 1'b1) begin
			n_compared++;
			if (exp_q.size() == 0 || fetch_addr !== exp_q[0]) begin
				bad_count++;
				$display("Error at %0t: unexpected fetch address", $time);
			end
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (pipe_flush === 1'b1) n_flush++;
		if (cycles == 6000) begin
			bad_count++;
			wrap_up();
		end
	end
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		void'($urandom(32'h1BFBB23D));
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		@(negedge clock);
		chk(mgmt_active_n, 1'b1);
		chk(internal_clk_en, 1'b1);
		for (i = 0; i < 4; i++) begin
			dss = $urandom;
			cfn = $urandom;
			{drive_strength_select, cache_flush_n, cpu_reset} = {dss, cfn, 1'b1};
			exp_q.push_back(`RESET_VECTOR);
			repeat (`WARM_HOLD_CYCLES) @(negedge clock);
			chk(core_flush, 1'b1);
			cpu_reset = 1'b0;
			repeat (6) @(negedge clock);
			chk(strong_drive, dss);
			chk(tristate_test, !cfn);
		end
		for (m = 0; m < 2; m++) begin
			wbe_mask = m[0];
			ready_delay = $urandom_range(0, 3);
			drain_delay = $urandom_range(6, 9);
			bus_idle = 1'b0;
			pulse(3);
			repeat (3) @(negedge clock);
			pulse(0);
			pulse(2);
			repeat (ready_delay + 4) @(negedge clock);
			bus_idle = 1'b1;
			exp_q.push_back(`MGMT_BASE);
			if (m == 0) begin
				repeat (2) @(negedge clock);
				chk(mgmt_active_n, 1'b1);
			end
			wait_sig(0, 1'b0);
			chk(nmi_block, 1'b1);
			pulse(3);
			repeat (3) @(negedge clock);
			pulse(0);
			pulse(2);
			repeat (10) @(negedge clock);
			chk(mgmt_active_n, 1'b0);
			pulse(1);
			pulse(2);
			chk(mgmt_active_n, 1'b0);
			wait_sig(0, 1'b1);
			exp_q.push_back(`MGMT_BASE);
			pulse(0);
			wait_sig(0, 1'b0);
			pulse(1);
			pulse(2);
			wait_sig(0, 1'b1);
		end
		clock_halt_request_n = 1'b0;
		bus_idle = 1'b0;
		repeat (4) @(negedge clock);
		chk(stop_grant, 1'b0);
		pulse(0);
		repeat (2) @(negedge clock);
		bus_idle = 1'b1;
		wait_sig(1, 1'b1);
		wait_sig(2, 1'b1);
		chk(internal_clk_en, 1'b0);
		clock_halt_request_n = 1'b1;
		wait_sig(2, 1'b0);
		chk(internal_clk_en, 1'b1);
		chk(n_flush == 5, 1'b1);
		chk(exp_q.size() == 0, 1'b1);
		wrap_up();
	end
endmodule : cpu_system_control_sequencer_tb
